// ### design/mmd_pkg.sv
/*
 * Constants of the data-memory decoder of a 4-bit microcontroller.
 * Assumes one system clock and one asynchronous active-low initial reset.
 */
// What this block does
// - Program memory is 1,536 words of 12 bits, six pages of 256 steps.
// - After reset, fetch starts at page 1, step 00H.
// - Interrupt vectors sit at page 1, steps 01H to 07H.
// - Calls and interrupts push three 4-bit words onto the data-memory stack.
// - Pointer-relative operands reach only data addresses 000H to 00FH.
// - Addresses 000H to 08FH are 144 words of read/write RAM.
// - Addresses 090H to 0AFH are 32 words of write-only display memory.
// - Data space spans 188 words: 144 RAM, 32 display and 12 I/O words.
// - Address 0E4H reads the 2, 4, 8 and 16 Hz timer taps.
// - Four input-line interrupt enables, 1 enables, all 0 at reset.
// - Address 0EBH holds 2, 8, 32 Hz timer enables; D3 reads 0.
// - Address 0EDH bit D0 is the input interrupt flag, 0 at reset.
// - Address 0EFH holds 2, 8, 32 Hz timer flags, 0 at reset.
// - Output port bits reset to 0 and drive their pins as written.
// - Interrupt flags clear to 0 right after being read, except those whose event arrives in the read cycle.
// - Unused I/O bits read 0 and ignore writes.
package mmd_pkg;
    localparam int ROM_WORDS = 1536;
    localparam int ROM_STEPS = 256;
    localparam int ROM_PAGES = 6;
    localparam logic [3:0] RESET_PAGE = 4'h1;
    localparam logic [7:0] RESET_STEP = 8'h00;
    localparam logic [7:0] VECTOR_FIRST = 8'h01;
    localparam logic [7:0] VECTOR_LAST = 8'h07;
    localparam int STACK_WORDS_PER_CALL = 3;
    localparam logic [7:0] SHORT_AREA_LAST = 8'h0f;
    localparam logic [7:0] RAM_FIRST = 8'h00;
    localparam logic [7:0] RAM_LAST = 8'h8f;
    localparam int RAM_WORDS = 144;
    localparam logic [7:0] DISP_FIRST = 8'h90;
    localparam logic [7:0] DISP_LAST = 8'haf;
    localparam int DISP_WORDS = 32;
    localparam int DATA_WORDS = 188;
    localparam int IO_WORDS = 12;
    localparam logic [7:0] ADDR_INPUT_PORT = 8'he0;
    localparam logic [7:0] ADDR_TIMER_TAPS = 8'he4;
    // Input enable, timer enable, flag and output port offsets follow.
    localparam logic [7:0] ADDR_INPUT_IRQ_EN = 8'he8;
    localparam logic [7:0] ADDR_TIMER_IRQ_EN = 8'heb;
    localparam logic [7:0] ADDR_INPUT_IRQ_FLAG = 8'hed;
    localparam logic [7:0] ADDR_TIMER_IRQ_FLAG = 8'hef;
    localparam logic [7:0] ADDR_OUTPUT_PORT = 8'hf3;
    localparam logic [3:0] RESET_ZERO = 4'h0;
    localparam logic [3:0] UNDEF_READ = 4'h0;
    localparam logic [2:0] TIMER_FIELD_MASK = 3'h7;
    localparam int BIT_2HZ = 2;
    localparam int BIT_8HZ = 1;
    localparam int BIT_32HZ = 0;
endpackage : mmd_pkg

// ### design/mmd_ram.sv
/*
 * Word memory with registered read data.
 * Assumes one clock; contents are not reset.
 */
`timescale 1ns/1ps
module mmd_ram #(
    parameter int WORDS = 144,
    parameter int AW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [3:0] wdata_i,
    output logic [3:0] rdata_o
);
    // Refuses a depth that the address cannot reach.
    if (WORDS < 1 || WORDS > (1 << AW)) begin : g_bad_depth
        $error("Memory depth does not fit the address width.");
    end
    logic [3:0] mem [WORDS];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : mmd_ram

// ### design/mmd_decode.sv
/*
 * Data-memory map decoder with RAM, display memory and I/O registers.
 * Assumes the CPU core issues one-cycle read or write strobes, and reads
 * data one cycle after the read strobe.
 */
`timescale 1ns/1ps
module mmd_decode #(
    parameter int RAM_WORDS = mmd_pkg::RAM_WORDS,
    parameter int DISP_WORDS = mmd_pkg::DISP_WORDS
) (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // CPU data-memory access.
    input wire logic [7:0] ADDR_I,
    input wire logic RD_I,
    input wire logic WR_I,
    input wire logic [3:0] WDATA_I,
    output logic [3:0] RDATA_O,
    output logic RVALID_O,
    // Program counter start.
    output logic [3:0] FETCH_PAGE_O,
    output logic [7:0] FETCH_STEP_O,
    // Peripheral inputs.
    input wire logic [3:0] INPUT_PORT_LINES_I,
    input wire logic [3:0] TIMER_TAP_BITS_I,
    input wire logic [2:0] TIMER_EVENT_I,
    // Peripheral outputs.
    output logic [3:0] OUTPUT_PORT_BITS_O,
    output logic [3:0] INPUT_IRQ_ENABLE_BITS_O,
    output logic [2:0] TIMER_IRQ_ENABLES_O,
    output logic INPUT_IRQ_FLAG_O,
    output logic [2:0] TIMER_IRQ_FLAGS_O,
    output logic DISP_WE_O,
    output logic [4:0] DISP_ADDR_O,
    output logic [3:0] DISP_DATA_O
);
    // Refuses memory sizes that the fixed address map cannot serve.
    if (RAM_WORDS != mmd_pkg::RAM_WORDS || DISP_WORDS != mmd_pkg::DISP_WORDS) begin : g_bad_size
        $error("Unsupported memory sizes.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    logic hit_ram;
    logic hit_disp;
    logic [3:0] io_rdata;
    logic io_hit;
    always_comb begin
        hit_ram = (ADDR_I <= mmd_pkg::RAM_LAST);
        hit_disp = (ADDR_I >= mmd_pkg::DISP_FIRST) && (ADDR_I <= mmd_pkg::DISP_LAST);
    end

    ////////////////////////////////////////////////////////////////////////
    // General RAM.
    logic [3:0] ram_rdata;
    mmd_ram #(.WORDS(RAM_WORDS), .AW(8)) u_ram (
        .clk_i(CLK_I),
        .we_i(WR_I && hit_ram),
        .addr_i(hit_ram ? ADDR_I : 8'h00),
        .wdata_i(WDATA_I),
        .rdata_o(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Display memory port, write only.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DISP_WE_O <= 1'b0;
            DISP_ADDR_O <= 5'h00;
            DISP_DATA_O <= 4'h0;
        end else begin
            DISP_WE_O <= WR_I && hit_disp;
            DISP_ADDR_O <= ADDR_I[4:0] ^ mmd_pkg::DISP_FIRST[4:0];
            DISP_DATA_O <= WDATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter start values.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            FETCH_PAGE_O <= mmd_pkg::RESET_PAGE;
            FETCH_STEP_O <= mmd_pkg::RESET_STEP;
        end else begin
            FETCH_PAGE_O <= mmd_pkg::RESET_PAGE;
            FETCH_STEP_O <= mmd_pkg::RESET_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable I/O registers.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INPUT_IRQ_ENABLE_BITS_O <= mmd_pkg::RESET_ZERO;
            TIMER_IRQ_ENABLES_O <= 3'h0;
            OUTPUT_PORT_BITS_O <= mmd_pkg::RESET_ZERO;
        end else if (WR_I) begin
            if (ADDR_I == mmd_pkg::ADDR_INPUT_IRQ_EN) begin
                INPUT_IRQ_ENABLE_BITS_O <= WDATA_I;
            end else if (ADDR_I == mmd_pkg::ADDR_TIMER_IRQ_EN) begin
                TIMER_IRQ_ENABLES_O <= WDATA_I[2:0] & mmd_pkg::TIMER_FIELD_MASK;
            end else if (ADDR_I == mmd_pkg::ADDR_OUTPUT_PORT) begin
                OUTPUT_PORT_BITS_O <= WDATA_I;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt factor flags; a new event wins over the read clear.
    logic [3:0] in_prev_q;
    logic [3:0] in_rise;
    logic rd_in_flag;
    logic rd_tm_flag;
    always_comb begin
        in_rise = INPUT_PORT_LINES_I & ~in_prev_q & INPUT_IRQ_ENABLE_BITS_O;
        rd_in_flag = RD_I && (ADDR_I == mmd_pkg::ADDR_INPUT_IRQ_FLAG);
        rd_tm_flag = RD_I && (ADDR_I == mmd_pkg::ADDR_TIMER_IRQ_FLAG);
    end
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            in_prev_q <= 4'h0;
        end else begin
            in_prev_q <= INPUT_PORT_LINES_I;
        end
    end
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INPUT_IRQ_FLAG_O <= 1'b0;
        end else if (|in_rise) begin
            INPUT_IRQ_FLAG_O <= 1'b1;
        end else if (rd_in_flag) begin
            INPUT_IRQ_FLAG_O <= 1'b0;
        end
    end
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TIMER_IRQ_FLAGS_O <= 3'h0;
        end else begin
            TIMER_IRQ_FLAGS_O <= (rd_tm_flag ? 3'h0 : TIMER_IRQ_FLAGS_O)
                               | TIMER_EVENT_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O read mux; reads have no side effects except flag clearing.
    always_comb begin
        io_hit = 1'b1;
        io_rdata = mmd_pkg::UNDEF_READ;
        if (ADDR_I == mmd_pkg::ADDR_INPUT_PORT) begin
            io_rdata = INPUT_PORT_LINES_I;
        end else if (ADDR_I == mmd_pkg::ADDR_TIMER_TAPS) begin
            io_rdata = TIMER_TAP_BITS_I;
        end else if (ADDR_I == mmd_pkg::ADDR_INPUT_IRQ_EN) begin
            io_rdata = INPUT_IRQ_ENABLE_BITS_O;
        end else if (ADDR_I == mmd_pkg::ADDR_TIMER_IRQ_EN) begin
            io_rdata = {1'b0, TIMER_IRQ_ENABLES_O};
        end else if (ADDR_I == mmd_pkg::ADDR_INPUT_IRQ_FLAG) begin
            io_rdata = {3'h0, INPUT_IRQ_FLAG_O};
        end else if (ADDR_I == mmd_pkg::ADDR_TIMER_IRQ_FLAG) begin
            io_rdata = {1'b0, TIMER_IRQ_FLAGS_O};
        end else if (ADDR_I == mmd_pkg::ADDR_OUTPUT_PORT) begin
            io_rdata = OUTPUT_PORT_BITS_O;
        end else begin
            io_hit = 1'b0;
        end
    end

    logic sel_ram_q;
    logic [3:0] io_rdata_q;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sel_ram_q <= 1'b0;
            io_rdata_q <= 4'h0;
            RVALID_O <= 1'b0;
        end else begin
            sel_ram_q <= RD_I && hit_ram;
            io_rdata_q <= io_hit ? io_rdata : mmd_pkg::UNDEF_READ;
            RVALID_O <= RD_I;
        end
    end
    always_comb begin
        RDATA_O = sel_ram_q ? ram_rdata : io_rdata_q;
    end
endmodule : mmd_decode

// ### dv/mmd_decode_chk.sv
/*
 * Port checker of the data-memory decoder.
 * Assumes it is bound to mmd_decode and sees its ports by name.
 */
`timescale 1ns/1ps
module mmd_decode_chk (
    // Watched ports.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic RD_I,
    input wire logic WR_I,
    input wire logic [3:0] WDATA_I,
    input wire logic [3:0] RDATA_O,
    input wire logic RVALID_O,
    input wire logic [3:0] FETCH_PAGE_O,
    input wire logic [7:0] FETCH_STEP_O,
    input wire logic [3:0] TIMER_TAP_BITS_I,
    input wire logic [2:0] TIMER_EVENT_I,
    input wire logic [3:0] OUTPUT_PORT_BITS_O,
    input wire logic [2:0] TIMER_IRQ_ENABLES_O,
    input wire logic INPUT_IRQ_FLAG_O,
    input wire logic [2:0] TIMER_IRQ_FLAGS_O,
    input wire logic DISP_WE_O,
    input wire logic [4:0] DISP_ADDR_O,
    input wire logic [3:0] DISP_DATA_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_fetch; FETCH_PAGE_O == 4'h1 && FETCH_STEP_O == 8'h00; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch start");
    property p_rvalid; 1'b1 |=> RVALID_O == $past(RD_I); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer");
    property p_taps; RD_I && ADDR_I == 8'he4 |=> RDATA_O == $past(TIMER_TAP_BITS_I); endproperty
    a_taps: assert property (p_taps) else $error("timer taps");
    property p_ten;
        RD_I && ADDR_I == 8'heb |=> RDATA_O == {1'b0, $past(TIMER_IRQ_ENABLES_O)};
    endproperty
    a_ten: assert property (p_ten) else $error("timer enables");
    property p_iflag;
        RD_I && ADDR_I == 8'hed |=> RDATA_O == {3'h0, $past(INPUT_IRQ_FLAG_O)};
    endproperty
    a_iflag: assert property (p_iflag) else $error("input flag");
    property p_tset;
        |TIMER_EVENT_I |=> (TIMER_IRQ_FLAGS_O & $past(TIMER_EVENT_I)) == $past(TIMER_EVENT_I);
    endproperty
    a_tset: assert property (p_tset) else $error("timer flag set");
    property p_tclr;
        RD_I && ADDR_I == 8'hef && TIMER_EVENT_I == 3'h0 |=> TIMER_IRQ_FLAGS_O == 3'h0;
    endproperty
    a_tclr: assert property (p_tclr) else $error("flag clear");
    property p_out; WR_I && ADDR_I == 8'hf3 |=> OUTPUT_PORT_BITS_O == $past(WDATA_I); endproperty
    a_out: assert property (p_out) else $error("output port");
    property p_disp;
        WR_I && ADDR_I inside {[8'h90:8'haf]} |=> DISP_WE_O && DISP_DATA_O == $past(WDATA_I)
            && {3'h0, DISP_ADDR_O} == $past(ADDR_I) - 8'h90;
    endproperty
    a_disp: assert property (p_disp) else $error("display write");
    property p_unm; RD_I && ADDR_I inside {[8'hb0:8'hdf]} |=> RDATA_O == 4'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
endmodule : mmd_decode_chk

bind mmd_decode mmd_decode_chk i_chk (.*);

// ### dv/mmd_cpu_model.sv
/*
 * CPU core model issuing one data-memory access at a time.
 * Assumes one-cycle strobes and read data one cycle after the strobe.
 */
`timescale 1ns/1ps
module mmd_cpu_model (
    // Clock and answer.
    input wire logic clk_i,
    input wire logic [3:0] rdata_i,
    input wire logic rvalid_i,
    // Request.
    output logic [7:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [3:0] wdata_o
);
    initial begin
        addr_o = 8'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 4'h0;
    end
    // Unused areas are touched only where a probe asks for it.
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] d,
                       output logic [3:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        rd_o <= ~w;
        wr_o <= w;
        @(posedge clk_i);
        addr_o <= ~a;
        wdata_o <= ~d;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        @(posedge clk_i);
        q = (rvalid_i === 1'b1) ? rdata_i : 4'hx;
    endtask : acc
endmodule : mmd_cpu_model

// ### dv/tb_top.sv
/*
 * Self-checking bench of the data-memory decoder.
 * Assumes the checker is bound in and the CPU model drives the access port.
 */
`timescale 1ns/1ps
module tb_top;
    logic CLK_I, RST_N_I, RD_I, WR_I, RVALID_O, INPUT_IRQ_FLAG_O, DISP_WE_O;
    logic [7:0] ADDR_I, FETCH_STEP_O;
    logic [3:0] WDATA_I, RDATA_O, FETCH_PAGE_O, INPUT_PORT_LINES_I, TIMER_TAP_BITS_I, q;
    logic [3:0] OUTPUT_PORT_BITS_O, INPUT_IRQ_ENABLE_BITS_O, DISP_DATA_O;
    logic [2:0] TIMER_EVENT_I, TIMER_IRQ_ENABLES_O, TIMER_IRQ_FLAGS_O;
    logic [4:0] DISP_ADDR_O;
    int miscompares = 0;
    int n_checks = 0;
    // Rows: write flag, address, write data, expected read data.
    logic [16:0] rows [17] = '{17'h1_00_5_0, 17'h0_00_0_5, 17'h1_8f_a_0, 17'h0_8f_0_a,
        17'h1_90_3_0, 17'h0_90_0_0, 17'h1_e8_f_0, 17'h0_e8_0_f, 17'h1_eb_f_0, 17'h0_eb_0_7,
        17'h1_ed_f_0, 17'h0_ed_0_0, 17'h1_e4_0_0, 17'h0_e4_0_9, 17'h0_c0_0_0, 17'h1_f3_5_0,
        17'h0_f3_0_5};
    mmd_decode i_dut (.*);
    mmd_cpu_model i_cpu (.clk_i(CLK_I), .rdata_i(RDATA_O), .rvalid_i(RVALID_O),
        .addr_o(ADDR_I), .rd_o(RD_I), .wr_o(WR_I), .wdata_o(WDATA_I));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end
    initial begin
        repeat (1000) @(posedge CLK_I);
        miscompares++;
        close_out();
    end
    initial begin
        RST_N_I = 1'b0;
        INPUT_PORT_LINES_I = 4'h0;
        TIMER_TAP_BITS_I = 4'h9;
        TIMER_EVENT_I = 3'h0;
        repeat (6) @(posedge CLK_I);
        chk({4'h0, FETCH_PAGE_O}, 8'h01);
        RST_N_I <= 1'b1;
        @(posedge CLK_I);
        chk({FETCH_PAGE_O, OUTPUT_PORT_BITS_O}, 8'h10);
        chk(FETCH_STEP_O, 8'h00);
        chk({INPUT_IRQ_ENABLE_BITS_O, 1'b0, TIMER_IRQ_ENABLES_O}, 8'h00);
        chk({3'h0, INPUT_IRQ_FLAG_O, 1'b0, TIMER_IRQ_FLAGS_O}, 8'h00);
        foreach (rows[i]) begin
            i_cpu.acc(rows[i][16], rows[i][15:8], rows[i][7:4], q);
            if (!rows[i][16])
                chk({4'h0, q}, {4'h0, rows[i][3:0]});
        end
        chk({4'h0, OUTPUT_PORT_BITS_O}, 8'h05);
        TIMER_EVENT_I <= 3'h5;
        @(posedge CLK_I);
        TIMER_EVENT_I <= 3'h0;
        for (int k = 0; k < 2; k++) begin
            i_cpu.acc(1'b0, 8'hef, 4'h0, q);
            chk({4'h0, q}, k ? 8'h00 : 8'h05);
        end
        INPUT_PORT_LINES_I <= 4'h1;
        for (int k = 0; k < 2; k++) begin
            i_cpu.acc(1'b0, 8'hed, 4'h0, q);
            chk({4'h0, q}, k ? 8'h00 : 8'h01);
        end
        i_cpu.acc(1'b0, 8'he0, 4'h0, q);
        chk({4'h0, q}, 8'h01);
        fork
            i_cpu.acc(1'b0, 8'hef, 4'h0, q);
            begin
                @(posedge CLK_I);
                TIMER_EVENT_I <= 3'h2;
                @(posedge CLK_I);
                TIMER_EVENT_I <= 3'h0;
            end
        join
        chk({4'h0, q}, 8'h00);
        i_cpu.acc(1'b0, 8'hef, 4'h0, q);
        chk({4'h0, q}, 8'h02);
        i_cpu.acc(1'b1, 8'hf3, 4'ha, q);
        chk({4'h0, OUTPUT_PORT_BITS_O}, 8'h0a);
        RST_N_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        chk({OUTPUT_PORT_BITS_O, INPUT_IRQ_ENABLE_BITS_O}, 8'h00);
        chk({FETCH_PAGE_O, 1'b0, TIMER_IRQ_ENABLES_O}, 8'h10);
        chk({RVALID_O, INPUT_IRQ_FLAG_O, 3'h0, TIMER_IRQ_FLAGS_O}, 8'h00);
        RST_N_I <= 1'b1;
        @(posedge CLK_I);
        i_cpu.acc(1'b0, 8'he8, 4'h0, q);
        chk({4'h0, q}, 8'h00);
        i_cpu.acc(1'b0, 8'hf3, 4'h0, q);
        chk({4'h0, q}, 8'h00);
        close_out();
    end
endmodule : tb_top
